// file: core/placeholder_unused_none.sv
// Intentionally empty compilation unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: core/sbpe_defs.svh
// Constants for the serial boot programming entry block
`ifndef SBPE_DEFS_SVH
`define SBPE_DEFS_SVH
`define SBPE_BOOT_BASE 24'hFF_E000
`define SBPE_BOOT_LAST 24'hFF_FFFF
`define SBPE_USER_BLK_MASK 24'hFF_0000
`define SBPE_ID_LAST_IDX 3'h6
`define SBPE_BYTE_LAST_BIT 3'h7
`define SBPE_TX_BITS 4'h8
`define SBPE_UTX_BITS 4'hB
`define SBPE_UTX_IDLE 11'h7_FF
`define SBPE_STRAP_WAIT 2'h3
`define SBPE_BAUD_DIV 11'h43D
`define SBPE_BAUD_HALF 11'h21E
`endif

// file: core/sbpe_pkg.sv
// Types for the serial boot programming entry block
package sbpe_pkg;
  typedef enum logic [1:0] {m_off, m_sync, m_async} sbpe_mode_t;
  typedef enum logic [1:0] {u_idle, u_start, u_data, u_stop} sbpe_urx_t;
endpackage : sbpe_pkg

// file: core/sbpe_sio.sv
// Clock-synchronised serial engine with busy handshake
`timescale 1ns/1ps
`default_nettype none
`include "sbpe_defs.svh"
module sbpe_sio (
  input wire logic mclk,
  input wire logic rst,
  input wire logic en,
  input wire logic sclk_s,
  input wire logic rxd_s,
  input wire logic hold,
  input wire logic tx_load,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic txd,
  output logic busy
);
  logic sclk_d_r, sclk_d_nxt, rx_v_r, rx_v_nxt, txd_r, txd_nxt, busy_r, busy_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt, rx_d_r, rx_d_nxt, tx_sh_r, tx_sh_nxt;
  logic [2:0] rx_cnt_r, rx_cnt_nxt;
  logic [3:0] tx_cnt_r, tx_cnt_nxt;
  logic rise, fall;

  assign rise = en & sclk_s & ~sclk_d_r;
  assign fall = en & ~sclk_s & sclk_d_r;
  assign tx_ready = en & (tx_cnt_r == 4'h0);

  always_comb
  begin
    sclk_d_nxt = sclk_s;
    rx_sh_nxt = rx_sh_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_d_nxt = rx_d_r;
    rx_v_nxt = 1'b0;
    tx_sh_nxt = tx_sh_r;
    tx_cnt_nxt = tx_cnt_r;
    txd_nxt = txd_r;
    busy_nxt = busy_r;
    if (rise)
    begin
      rx_sh_nxt = {rxd_s, rx_sh_r[7:1]};
      busy_nxt = 1'b1;
      if (rx_cnt_r == `SBPE_BYTE_LAST_BIT)
      begin
        rx_cnt_nxt = 3'h0;
        rx_d_nxt = {rxd_s, rx_sh_r[7:1]};
        rx_v_nxt = 1'b1;
      end
      else
        rx_cnt_nxt = rx_cnt_r + 3'h1;
    end
    else if (rx_cnt_r == 3'h0 && tx_cnt_r == 4'h0 && !hold && !rx_v_r)
      busy_nxt = 1'b0;
    if (fall && tx_cnt_r != 4'h0)
    begin
      txd_nxt = tx_sh_r[0];
      tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
      tx_cnt_nxt = tx_cnt_r - 4'h1;
    end
    if (tx_load && tx_ready)
    begin
      tx_sh_nxt = tx_data;
      tx_cnt_nxt = `SBPE_TX_BITS;
      busy_nxt = 1'b1;
    end
    if (!en)
      busy_nxt = 1'b0;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sclk_d_r <= 1'b0;
      rx_sh_r <= 8'h00;
      rx_cnt_r <= 3'h0;
      rx_d_r <= 8'h00;
      rx_v_r <= 1'b0;
      tx_sh_r <= 8'h00;
      tx_cnt_r <= 4'h0;
      txd_r <= 1'b1;
      busy_r <= 1'b0;
    end
    else
    begin
      sclk_d_r <= sclk_d_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_d_r <= rx_d_nxt;
      rx_v_r <= rx_v_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      txd_r <= txd_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign rx_valid = rx_v_r;
  assign rx_data = rx_d_r;
  assign txd = txd_r;
  assign busy = busy_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_busy_on_rx: assert property (rise |=> busy_r)
    else $error("busy not raised on reception");
  a_rx_msb_last: assert property (rx_v_r |-> rx_d_r[7] == $past(rxd_s))
    else $error("last received bit not in msb");
  a_tx_on_fall: assert property (!$stable(txd_r) |-> $past(fall))
    else $error("transmit bit changed off a falling edge");
endmodule : sbpe_sio
`default_nettype wire

// file: core/sbpe_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module sbpe_sync #(parameter int W = 5) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
        end
        else
        begin
          s1_r[i] <= d[i];
          s2_r[i] <= s1_r[i];
        end
      end
    end
  endgenerate
  assign q = s2_r;
endmodule : sbpe_sync
`default_nettype wire

// file: core/sbpe_top.sv
// Serial programming mode entry, link engines, id gate and boot protection
`timescale 1ns/1ps
`default_nettype none
`include "sbpe_defs.svh"
// Notes on behaviour
// - Boot area is 8 Kbytes spanning FFE000 to FFFFFF.
// - Boot area erases as one single 8 Kbyte block.
// - User area blocks accept program and block erase.
// - Serial mode entered at reset release when select high, erase-mode low, mode pin high.
// - Transfer clock high at release picks synchronous mode 1, low picks asynchronous mode 2.
// - Both modes move commands, addresses and data in 8-bit units on one channel.
// - Mode 1 uses clock in, receive in, CMOS transmit out and busy out.
// - Busy low when ready, high as soon as reception starts.
// - Mode 2 uses only receive and transmit pins, no clock or busy.
// - In serial mode only user area may change; boot operations refused.
// - Non-blank flash rejects commands until the 7-byte id matches.
// - Bytes travel least significant bit first both ways.
// - Mode 1 captures received bits on transfer clock rise.
// - Mode 1 launches transmit bits on transfer clock fall.
module sbpe_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic program_select_pin,
  input wire logic erase_program_mode_in,
  input wire logic processor_mode_pin,
  input wire logic transfer_clock_pin,
  input wire logic serial_receive_pin,
  output logic serial_transmit_pin,
  output logic handshake_busy_pin,
  output sbpe_pkg::sbpe_mode_t serial_mode,
  output logic mode_valid,
  input wire logic flash_blank,
  input wire logic [55:0] stored_id,
  output logic id_ok,
  output logic cmd_valid,
  output logic [7:0] cmd_data,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  output logic resp_ready,
  input wire logic flash_busy,
  input wire logic op_req,
  input wire logic op_erase,
  input wire logic [23:0] op_addr,
  output logic op_go,
  output logic op_refused,
  output logic [23:0] op_first,
  output logic [23:0] op_last
);
  import sbpe_pkg::*;

  logic [4:0] pins_s;
  logic ps_s, erase_mode_s, cnv_s, sclk_s, rxd_s;
  sbpe_sync #(.W(5)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({serial_receive_pin, transfer_clock_pin, processor_mode_pin, erase_program_mode_in, program_select_pin}),
    .q(pins_s)
  );
  assign {rxd_s, sclk_s, cnv_s, erase_mode_s, ps_s} = pins_s;

  // Strap capture after reset release
  sbpe_mode_t mode_r, mode_nxt;
  logic [1:0] wait_r, wait_nxt;
  logic done_r, done_nxt, lat_en;
  assign lat_en = !done_r && wait_r == `SBPE_STRAP_WAIT;
  always_comb
  begin
    mode_nxt = mode_r;
    done_nxt = done_r;
    wait_nxt = wait_r;
    if (!done_r && wait_r != `SBPE_STRAP_WAIT)
      wait_nxt = wait_r + 2'h1;
    if (lat_en)
    begin
      done_nxt = 1'b1;
      if (ps_s && !erase_mode_s && cnv_s)
        mode_nxt = sclk_s ? m_sync : m_async;
      else
        mode_nxt = m_off;
    end
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mode_r <= m_off;
      done_r <= 1'b0;
      wait_r <= 2'h0;
    end
    else
    begin
      mode_r <= mode_nxt;
      done_r <= done_nxt;
      wait_r <= wait_nxt;
    end
  end
  logic act_sync, act_async;
  assign act_sync = done_r && mode_r == m_sync;
  assign act_async = done_r && mode_r == m_async;

  // Mode 1 engine
  logic s_rx_v, s_txd, s_busy, s_tx_rdy;
  logic [7:0] s_rx_d;
  sbpe_sio u_sio (
    .mclk(mclk),
    .rst(rst),
    .en(act_sync),
    .sclk_s(sclk_s),
    .rxd_s(rxd_s),
    .hold(flash_busy),
    .tx_load(resp_valid && act_sync),
    .tx_data(resp_data),
    .tx_ready(s_tx_rdy),
    .rx_valid(s_rx_v),
    .rx_data(s_rx_d),
    .txd(s_txd),
    .busy(s_busy)
  );

  // Mode 2 asynchronous receiver
  sbpe_urx_t urx_r, urx_nxt;
  logic [10:0] ubd_r, ubd_nxt;
  logic [2:0] ubit_r, ubit_nxt;
  logic [7:0] ush_r, ush_nxt, urd_r, urd_nxt;
  logic urv_r, urv_nxt;
  always_comb
  begin
    urx_nxt = urx_r;
    ubd_nxt = ubd_r;
    ubit_nxt = ubit_r;
    ush_nxt = ush_r;
    urd_nxt = urd_r;
    urv_nxt = 1'b0;
    if (ubd_r != 11'h000)
      ubd_nxt = ubd_r - 11'h001;
    case (urx_r)
      u_idle:
        if (act_async && !rxd_s)
        begin
          urx_nxt = u_start;
          ubd_nxt = `SBPE_BAUD_HALF;
        end
      u_start:
        if (ubd_r == 11'h000)
        begin
          urx_nxt = rxd_s ? u_idle : u_data;
          ubd_nxt = `SBPE_BAUD_DIV;
          ubit_nxt = 3'h0;
        end
      u_data:
        if (ubd_r == 11'h000)
        begin
          ush_nxt = {rxd_s, ush_r[7:1]};
          ubd_nxt = `SBPE_BAUD_DIV;
          if (ubit_r == `SBPE_BYTE_LAST_BIT)
            urx_nxt = u_stop;
          else
            ubit_nxt = ubit_r + 3'h1;
        end
      u_stop:
        if (ubd_r == 11'h000)
        begin
          urx_nxt = u_idle;
          urv_nxt = rxd_s;
          if (rxd_s)
            urd_nxt = ush_r;
        end
      default: urx_nxt = u_idle;
    endcase
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      urx_r <= u_idle;
      ubd_r <= 11'h000;
      ubit_r <= 3'h0;
      ush_r <= 8'h00;
      urd_r <= 8'h00;
      urv_r <= 1'b0;
    end
    else
    begin
      urx_r <= urx_nxt;
      ubd_r <= ubd_nxt;
      ubit_r <= ubit_nxt;
      ush_r <= ush_nxt;
      urd_r <= urd_nxt;
      urv_r <= urv_nxt;
    end
  end

  // Mode 2 asynchronous transmitter, start, 8 data, two stop
  logic [10:0] ufr_r, ufr_nxt, utb_r, utb_nxt;
  logic [3:0] utc_r, utc_nxt;
  logic utx_r, utx_nxt, u_tx_rdy;
  assign u_tx_rdy = act_async && utc_r == 4'h0;
  always_comb
  begin
    ufr_nxt = ufr_r;
    utb_nxt = utb_r;
    utc_nxt = utc_r;
    utx_nxt = utx_r;
    if (utc_r != 4'h0)
    begin
      if (utb_r == 11'h000)
      begin
        utx_nxt = ufr_r[0];
        ufr_nxt = {1'b1, ufr_r[10:1]};
        utc_nxt = utc_r - 4'h1;
        utb_nxt = `SBPE_BAUD_DIV;
      end
      else
        utb_nxt = utb_r - 11'h001;
    end
    else if (resp_valid && u_tx_rdy)
    begin
      ufr_nxt = {2'b11, resp_data, 1'b0};
      utc_nxt = `SBPE_UTX_BITS;
      utb_nxt = 11'h000;
    end
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ufr_r <= `SBPE_UTX_IDLE;
      utb_r <= 11'h000;
      utc_r <= 4'h0;
      utx_r <= 1'b1;
    end
    else
    begin
      ufr_r <= ufr_nxt;
      utb_r <= utb_nxt;
      utc_r <= utc_nxt;
      utx_r <= utx_nxt;
    end
  end

  // Identification gate
  logic byte_v, gate_open, id_hit;
  logic [7:0] byte_d;
  logic [2:0] idx_r, idx_nxt;
  logic bad_r, bad_nxt, idok_r, idok_nxt, cv_r, cv_nxt;
  logic [7:0] cd_r, cd_nxt;
  assign byte_v = act_sync ? s_rx_v : urv_r;
  assign byte_d = act_sync ? s_rx_d : urd_r;
  assign gate_open = flash_blank || idok_r;
  assign id_hit = byte_d == stored_id[{idx_r, 3'b000} +: 8];
  always_comb
  begin
    idx_nxt = idx_r;
    bad_nxt = bad_r;
    idok_nxt = idok_r;
    cd_nxt = cd_r;
    cv_nxt = byte_v && gate_open;
    if (byte_v && gate_open)
      cd_nxt = byte_d;
    if (byte_v && !gate_open)
    begin
      if (idx_r == `SBPE_ID_LAST_IDX)
      begin
        idx_nxt = 3'h0;
        bad_nxt = 1'b0;
        idok_nxt = !bad_r && id_hit;
      end
      else
      begin
        idx_nxt = idx_r + 3'h1;
        bad_nxt = bad_r || !id_hit;
      end
    end
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      idx_r <= 3'h0;
      bad_r <= 1'b0;
      idok_r <= 1'b0;
      cv_r <= 1'b0;
      cd_r <= 8'h00;
    end
    else
    begin
      idx_r <= idx_nxt;
      bad_r <= bad_nxt;
      idok_r <= idok_nxt;
      cv_r <= cv_nxt;
      cd_r <= cd_nxt;
    end
  end

  // Program and erase gating
  logic in_boot, serial_on, go_nxt, ref_nxt, go_r, ref_r;
  logic [23:0] first_r, first_nxt, last_r, last_nxt;
  assign in_boot = op_addr >= `SBPE_BOOT_BASE && op_addr <= `SBPE_BOOT_LAST;
  assign serial_on = mode_r != m_off;
  always_comb
  begin
    go_nxt = 1'b0;
    ref_nxt = 1'b0;
    first_nxt = first_r;
    last_nxt = last_r;
    if (op_req)
    begin
      if (serial_on && (in_boot || !gate_open))
        ref_nxt = 1'b1;
      else
      begin
        go_nxt = 1'b1;
        first_nxt = op_addr;
        last_nxt = op_addr;
        if (op_erase && in_boot)
        begin
          first_nxt = `SBPE_BOOT_BASE;
          last_nxt = `SBPE_BOOT_LAST;
        end
        else if (op_erase)
        begin
          first_nxt = op_addr & `SBPE_USER_BLK_MASK;
          last_nxt = op_addr | ~`SBPE_USER_BLK_MASK;
        end
      end
    end
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      go_r <= 1'b0;
      ref_r <= 1'b0;
      first_r <= 24'h00_0000;
      last_r <= 24'h00_0000;
    end
    else
    begin
      go_r <= go_nxt;
      ref_r <= ref_nxt;
      first_r <= first_nxt;
      last_r <= last_nxt;
    end
  end

  // Pins and user outputs
  logic txp_r, txp_nxt;
  always_comb
  begin
    txp_nxt = 1'b1;
    if (act_sync)
      txp_nxt = s_txd;
    else if (act_async)
      txp_nxt = utx_r;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      txp_r <= 1'b1;
    else
      txp_r <= txp_nxt;
  end
  assign serial_transmit_pin = txp_r;
  assign handshake_busy_pin = act_sync && s_busy;
  assign resp_ready = act_sync ? s_tx_rdy : u_tx_rdy;
  assign serial_mode = mode_r;
  assign mode_valid = done_r;
  assign id_ok = idok_r;
  assign cmd_valid = cv_r;
  assign cmd_data = cd_r;
  assign op_go = go_r;
  assign op_refused = ref_r;
  assign op_first = first_r;
  assign op_last = last_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_entry_sync: assert property (lat_en && ps_s && !erase_mode_s && cnv_s && sclk_s |=> mode_r == m_sync)
    else $error("mode 1 not entered");
  a_entry_async: assert property (lat_en && ps_s && !erase_mode_s && cnv_s && !sclk_s |=> mode_r == m_async)
    else $error("mode 2 not entered");
  a_mode_kept: assert property (done_r |=> $stable(mode_r) && done_r)
    else $error("mode changed after latch");
  a_boot_refused: assert property (op_req && serial_on && in_boot |=> ref_r && !go_r)
    else $error("boot operation not refused");
  a_boot_block: assert property (op_req && !serial_on && op_erase && in_boot |=> go_r
    && first_r == `SBPE_BOOT_BASE && last_r == `SBPE_BOOT_LAST)
    else $error("boot erase span wrong");
  a_user_allowed: assert property (op_req && !in_boot && gate_open |=> go_r && !ref_r)
    else $error("user operation not allowed");
  a_id_gate: assert property (cv_r |-> $past(gate_open))
    else $error("command passed without id");
  a_async_nobusy: assert property (act_async |-> !handshake_busy_pin)
    else $error("busy driven in mode 2");
endmodule : sbpe_top
`default_nettype wire

// file: verif/sbpe_prog_model.sv
// External serial programmer model for both link modes
`timescale 1ns/1ps
`default_nettype none
module sbpe_prog_model #(parameter int HALF = 4, parameter int BIT_MCLK = 1086) (
  input wire logic mclk,
  input wire logic busy,
  input wire logic txd,
  output logic sclk,
  output logic rxd
);
  initial
  begin
    sclk = 1'b1;
    rxd = 1'b1;
  end

  // Clock pin rests at the strap level outside frames
  task automatic rest(input logic lvl);
    sclk <= lvl;
    rxd <= 1'b1;
  endtask : rest

  // Mode 1 byte towards the device
  task automatic send_sync(input logic [7:0] b);
    int i;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000)
    begin
      @(posedge mclk);
      n++;
    end
    for (i = 0; i < 8; i++)
    begin
      sclk <= 1'b0;
      rxd <= b[i];
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b1;
      repeat (HALF) @(posedge mclk);
    end
    rxd <= ~b[7];
  endtask : send_sync

  // Mode 1 byte from the device, sampled late in the high phase
  task automatic recv_sync(output logic [7:0] b);
    int i;
    rxd <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      sclk <= 1'b0;
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b1;
      repeat (HALF - 1) @(posedge mclk);
      b[i] = txd;
      @(posedge mclk);
    end
  endtask : recv_sync

  // Mode 2 frame, start bit, data, stop bit
  task automatic send_async(input logic [7:0] b);
    logic [9:0] bits;
    int i;
    bits = {1'b1, b, 1'b0};
    for (i = 0; i < 10; i++)
    begin
      rxd <= bits[i];
      repeat (BIT_MCLK) @(posedge mclk);
    end
  endtask : send_async

  // Mode 2 frame from the device, sampled mid bit
  task automatic recv_async(output logic [7:0] b);
    int i;
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 4000)
    begin
      @(posedge mclk);
      n++;
    end
    repeat (BIT_MCLK / 2) @(posedge mclk);
    for (i = 0; i < 8; i++)
    begin
      repeat (BIT_MCLK) @(posedge mclk);
      b[i] = txd;
    end
  endtask : recv_async
endmodule : sbpe_prog_model
`default_nettype wire

// file: verif/tb_serial_boot_programming_entry.sv
// Testbench for serial programming entry, id gate and boot protection
`timescale 1ns/1ps
`default_nettype none
module tb_serial_boot_programming_entry;
  import sbpe_pkg::*;
  logic mclk, rst, program_select_pin, erase_program_mode_in, processor_mode_pin;
  logic transfer_clock_pin, serial_receive_pin, serial_transmit_pin, handshake_busy_pin;
  sbpe_mode_t serial_mode;
  logic mode_valid, flash_blank, id_ok, cmd_valid, resp_valid, resp_ready, flash_busy;
  logic [55:0] stored_id;
  logic [7:0] cmd_data, resp_data, rb;
  logic op_req, op_erase, op_go, op_refused;
  logic [23:0] op_addr, op_first, op_last;
  logic [7:0] rx_q[$];
  int bad_count, total_checks, busy_hits, cycle_count, h0;

  sbpe_top dut (.mclk, .rst, .program_select_pin, .erase_program_mode_in, .processor_mode_pin,
    .transfer_clock_pin, .serial_receive_pin, .serial_transmit_pin, .handshake_busy_pin,
    .serial_mode, .mode_valid, .flash_blank, .stored_id, .id_ok, .cmd_valid, .cmd_data,
    .resp_valid, .resp_data, .resp_ready, .flash_busy, .op_req, .op_erase, .op_addr,
    .op_go, .op_refused, .op_first, .op_last);

  sbpe_prog_model prog (.mclk(mclk), .busy(handshake_busy_pin), .txd(serial_transmit_pin),
    .sclk(transfer_clock_pin), .rxd(serial_receive_pin));

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  // Byte capture, busy count and hang limit
  always @(posedge mclk)
  begin
    if (cmd_valid === 1'b1)
      rx_q.push_back(cmd_data);
    if (handshake_busy_pin === 1'b1)
      busy_hits++;
    cycle_count++;
    if (cycle_count == 60000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks=%0d bad=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic do_reset(input logic sel, input logic ers, input logic cpu, input logic lvl,
    input sbpe_mode_t m);
    rst <= 1'b1;
    program_select_pin <= sel;
    erase_program_mode_in <= ers;
    processor_mode_pin <= cpu;
    prog.rest(lvl);
    repeat (20) @(posedge mclk);
    check_val(mode_valid, 1'b0);
    check_val(serial_transmit_pin, 1'b1);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    check_val(serial_mode, m);
    check_val(mode_valid, 1'b1);
  endtask : do_reset

  task automatic do_op(input logic er, input logic [23:0] a, input logic go, input logic [23:0] f,
    input logic [23:0] l);
    op_req <= 1'b1;
    op_erase <= er;
    op_addr <= a;
    @(posedge mclk);
    op_req <= 1'b0;
    #1;
    check_val({op_go, op_refused}, {go, ~go});
    if (go)
    begin
      check_val({op_first, op_last}, {f, l});
    end
    @(posedge mclk);
  endtask : do_op

  task automatic send_resp(input logic [7:0] d);
    int n;
    resp_data <= d;
    resp_valid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (resp_ready !== 1'b1 && n < 2000);
    resp_valid <= 1'b0;
  endtask : send_resp

  task automatic send_id(input logic wrong);
    int i;
    for (i = 0; i < 7; i++)
      prog.send_sync(stored_id[8*i +: 8] ^ {7'h00, wrong && i == 6});
    repeat (8) @(posedge mclk);
  endtask : send_id

  task automatic t_sync_gate();
    do_reset(1'b1, 1'b0, 1'b1, 1'b1, m_sync);
    check_val(serial_transmit_pin, 1'b1);
    do_op(1'b0, 24'h01_2345, 1'b0, 24'h00_0000, 24'h00_0000);
    h0 = busy_hits;
    send_id(1'b0);
    check_val(id_ok, 1'b1);
    check_val(64'(rx_q.size()), 64'h0);
    check_val(busy_hits > h0, 1'b1);
  endtask : t_sync_gate

  task automatic t_cmd_ops();
    flash_busy <= 1'b1;
    prog.send_sync(8'hA5);
    repeat (8) @(posedge mclk);
    check_val(handshake_busy_pin, 1'b1);
    flash_busy <= 1'b0;
    repeat (3) @(posedge mclk);
    check_val(handshake_busy_pin, 1'b0);
    check_val(64'(rx_q.size()), 64'h1);
    check_val(rx_q.pop_front(), 8'hA5);
    do_op(1'b0, 24'hFF_E123, 1'b0, 24'h00_0000, 24'h00_0000);
    do_op(1'b1, 24'hFF_FFFF, 1'b0, 24'h00_0000, 24'h00_0000);
    do_op(1'b0, 24'h01_2345, 1'b1, 24'h01_2345, 24'h01_2345);
    do_op(1'b1, 24'h03_ABCD, 1'b1, 24'h03_0000, 24'h03_FFFF);
    check_val(serial_mode, m_sync);
    send_resp(8'h3C);
    prog.recv_sync(rb);
    check_val(rb, 8'h3C);
    repeat (8) @(posedge mclk);
    check_val(64'(rx_q.size()), 64'h1);
    check_val(rx_q.pop_front(), 8'hFF);
  endtask : t_cmd_ops

  task automatic t_bad_id();
    do_reset(1'b1, 1'b0, 1'b1, 1'b1, m_sync);
    send_id(1'b1);
    check_val(id_ok, 1'b0);
    prog.send_sync(8'h41);
    repeat (8) @(posedge mclk);
    check_val(64'(rx_q.size()), 64'h0);
  endtask : t_bad_id

  task automatic t_async();
    do_reset(1'b1, 1'b0, 1'b1, 1'b0, m_async);
    flash_blank <= 1'b1;
    h0 = busy_hits;
    prog.send_async(8'h5A);
    repeat (8) @(posedge mclk);
    check_val(64'(rx_q.size()), 64'h1);
    check_val(rx_q.pop_front(), 8'h5A);
    check_val(busy_hits == h0, 1'b1);
    send_resp(8'hC3);
    prog.recv_async(rb);
    check_val(rb, 8'hC3);
  endtask : t_async

  task automatic t_off();
    do_reset(1'b0, 1'b0, 1'b1, 1'b1, m_off);
    do_reset(1'b1, 1'b1, 1'b1, 1'b1, m_off);
    do_reset(1'b1, 1'b0, 1'b0, 1'b1, m_off);
    do_op(1'b1, 24'hFF_E800, 1'b1, 24'hFF_E000, 24'hFF_FFFF);
  endtask : t_off

  initial
  begin
    rst <= 1'b1;
    program_select_pin <= 1'b0;
    erase_program_mode_in <= 1'b0;
    processor_mode_pin <= 1'b0;
    flash_blank <= 1'b0;
    stored_id <= 56'h11_2233_4455_6677;
    resp_valid <= 1'b0;
    resp_data <= 8'h00;
    flash_busy <= 1'b0;
    op_req <= 1'b0;
    op_erase <= 1'b0;
    op_addr <= 24'h00_0000;
    @(posedge mclk);
    t_sync_gate();
    t_cmd_ops();
    t_bad_id();
    t_async();
    t_off();
    give_verdict();
  end
endmodule : tb_serial_boot_programming_entry
`default_nettype wire
